// ===== hw/prd_map.svh
`ifndef PRD_MAP_SVH
`define PRD_MAP_SVH

// register byte offsets
`define PRD_OFS_CTRL      8'h00
`define PRD_OFS_UNIT      8'h04
`define PRD_OFS_MON       8'h08
`define PRD_OFS_STAT      8'h0c

// control register fields
`define PRD_CTRL_FMT_LSB  0
`define PRD_CTRL_FMT_MSB  2
`define PRD_CTRL_WIDE     3
`define PRD_CTRL_CARD16   4

// status register fields
`define PRD_STAT_VALID    0
`define PRD_STAT_BCD_ERR  1
`define PRD_STAT_RNG_ERR  2
`define PRD_STAT_FMT_ERR  3
`define PRD_STAT_REVERSE  4

// reset values
`define PRD_CTRL_RST      5'h00
`define PRD_UNIT_RST      16'h0000

// display unit boundaries
`define PRD_UNIT_RPM_LO   16'h0002
`define PRD_UNIT_RPM_HI   16'h0027
`define PRD_UNIT_USER_LO  16'h0028

// full-scale and limit counts
`define PRD_FULL_PCT      40'h0000002710
`define PRD_LIM_PCT       40'h0000002af8
`define PRD_LIM_HZ        40'h0000009c40
`define PRD_LIM_HZ_FINE   40'h0000003e7f
`define PRD_LIM_BCD5      40'h0000009c3e
`define PRD_LIM_RPM12     40'h000000063f
`define PRD_LIM_RPM16     40'h0000003e7f
`define PRD_LIM_USER      40'h0000002af8
`define PRD_LIM_BIN16     40'h00000080e8
`define PRD_BIN_FULL8     40'h00000000ff
`define PRD_BIN_FULL12    40'h0000000fff
`define PRD_BIN_FULL16    40'h0000007530

// default top frequency in 0.01 Hz, arbitrary
`define PRD_MAX_FREQ_CHZ  40'h0000001770

`endif

// ===== hw/prd_pkg.sv
package prd_pkg;

	typedef enum logic [2:0] {
		PRD_FMT_PCT1   = 3'b000,
		PRD_FMT_PCT01  = 3'b001,
		PRD_FMT_PCT001 = 3'b010,
		PRD_FMT_HZ1    = 3'b011,
		PRD_FMT_HZ01   = 3'b100,
		PRD_FMT_HZ001  = 3'b101,
		PRD_FMT_BCD5   = 3'b110,
		PRD_FMT_BIN    = 3'b111
	} prd_fmt_t;

	typedef struct packed {
		logic [15:0] data;
		logic        sign;
		logic        strobe;
	} prd_pins_t;

	typedef struct packed {
		logic reverse;
		logic fmt_err;
		logic rng_err;
		logic bcd_err;
		logic valid;
	} prd_status_t;

endpackage : prd_pkg

// ===== hw/prd_bcd_digit.sv
`timescale 1ns/100ps
`default_nettype none

module prd_bcd_digit (
	// nibble in
	input  wire logic [3:0] nib,
	// decoded digit
	output logic      [3:0] value,
	output logic            bad
);
	always_comb begin
		value = nib;
		bad   = (nib > 4'h9);
	end
endmodule : prd_bcd_digit

`default_nettype wire

// ===== hw/prd_decoder.sv
// Function
// [RL1] binary formats: all ones gives 100 percent reference.
// [RL2] five-digit unsigned format only on 16-bit card, up to 399.98 Hz.
// [RL3] unsigned five-digit format uses sign line as a data bit.
// [RL4] unsigned format lowest digit starts at zero, step 0.02 Hz.
// [RL5] 8-bit card gives no reference with format 6; the code flags it only for display units 0 and 1.
// [RL6] 8-bit binary: eight weighted bits plus sign, range -255 to 255.
// [RL7] 8-bit format 0: two signed BCD digits, 1 percent, limit 110.
// [RL8] 8-bit formats 1, 2: two BCD digits in 0.1 and 0.01 percent.
// [RL9] 8-bit formats 3 to 5: two BCD digits in 1, 0.1, 0.01 Hz.
// [RL10] 16-bit format 0: three or four BCD digits by width, limit 110.
// [RL11] 16-bit format 3 wide: four BCD digits, 1 Hz, limit 400.
// [RL12] 16-bit format 5 wide: four BCD digits, 0.01 Hz, limit 159.99.
// [RL13] format 6 wide: five unsigned BCD digits, 0.01 Hz, up to 399.98.
// [RL14] format 7 wide: signed binary, 30000 is 100 percent, limit 33000.
// [RL15] display unit 2 to 39: BCD rpm, limit 1599 or 15999 by width.
// [RL16] display unit user scale: four BCD digits, limit 11000 counts; decoded as two digits on 8-bit card, three at 12-bit width.
// [RL17] monitor in 0.01 Hz for display unit 0, 0.01 percent for 1.
// [RL18] 16-bit card decoding depends on format and width switch together.
// [RL19] word captured only while strobe active; sign zero means forward.
// [RL20] illegal BCD digits are flagged and produce no reference; the code leaves the 8-bit card's upper digit unchecked.
`timescale 1ns/100ps
`default_nettype none
`include "prd_map.svh"

module prd_decoder (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// reference lines from the controller
	input  wire prd_pkg::prd_pins_t pins,
	// register port
	input  wire logic [7:0]        bus_addr,
	input  wire logic [31:0]       bus_wdata,
	input  wire logic              bus_wr,
	input  wire logic              bus_rd,
	output logic      [31:0]       bus_rdata,
	// decoded reference
	output logic      [31:0]       reference_monitor,
	output prd_pkg::prd_status_t   status
);
	import prd_pkg::*;

	prd_pins_t   pins_meta;
	prd_pins_t   pins_s;
	logic [4:0]  ctrl;
	logic [15:0] display_unit_select;
	logic [31:0] next_rdata;
	logic [4:0]  next_ctrl;
	logic [15:0] next_unit;
	logic [31:0] next_mon;
	prd_status_t next_status;
	prd_fmt_t    input_format_select;
	logic        word_width_switch;
	logic        card16;
	logic [3:0]  nib [4];
	logic [3:0]  dig [4];
	logic [3:0]  dig_bad;
	logic [3:0]  dig5;
	logic [39:0] mag;
	logic [39:0] val;
	logic [39:0] lim;
	logic [39:0] conv;
	logic [39:0] raw;
	logic [39:0] full;
	logic        is_pct;
	logic        is_hz;
	logic        bcd_err;
	logic        rng_err;
	logic        fmt_err;
	logic        neg;
	logic        use_d2;
	logic        use_d3;

	assign input_format_select = prd_fmt_t'(ctrl[`PRD_CTRL_FMT_MSB:`PRD_CTRL_FMT_LSB]);
	assign word_width_switch   = ctrl[`PRD_CTRL_WIDE];
	assign card16              = ctrl[`PRD_CTRL_CARD16];

	// pins come from another board: two flops before any use
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pins_meta <= '0;
			pins_s    <= '0;
		end else begin
			pins_meta <= pins;
			pins_s    <= pins_meta;
		end
	end

	// nibble routing; format 6 shifts digits down one line, lowest weight implied zero
	always_comb begin
		if (input_format_select == PRD_FMT_BCD5) begin
			nib[0] = {pins_s.data[2:0], 1'b0}; // [RL4]
			nib[1] = pins_s.data[6:3];
			nib[2] = pins_s.data[10:7];
			nib[3] = pins_s.data[14:11];
			dig5   = {2'b00, pins_s.sign, pins_s.data[15]}; // [RL3]
		end else begin
			nib[0] = pins_s.data[3:0];
			nib[1] = pins_s.data[7:4];
			nib[2] = pins_s.data[11:8];
			nib[3] = pins_s.data[15:12];
			dig5   = 4'h0;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_digit
			prd_bcd_digit u_digit (
				.nib   (nib[gi]),
				.value (dig[gi]),
				.bad   (dig_bad[gi])
			);
		end
	endgenerate

	// BCD magnitude: digit count follows card and width switch
	always_comb begin
		use_d2 = card16; // [RL18]
		use_d3 = card16 && word_width_switch; // [RL10]
		mag = 40'(dig[0]) + 40'(dig[1]) * 40'd10;
		if (use_d2) begin
			mag = mag + 40'(dig[2]) * 40'd100;
		end
		if (use_d3) begin
			mag = mag + 40'(dig[3]) * 40'd1000;
		end
		if (input_format_select == PRD_FMT_BCD5) begin
			mag = mag + 40'(dig5) * 40'd10000; // [RL13]
		end
		// narrow card's upper digit may run to 15
		bcd_err = dig_bad[0] || (dig_bad[1] && card16) || (dig_bad[2] && use_d2) ||
			(dig_bad[3] && use_d3); // [RL20]
	end

	// scale to 0.01 Hz, 0.01 % or raw counts, then range check
	always_comb begin
		val     = mag;
		lim     = `PRD_LIM_PCT;
		is_pct  = 1'b0;
		is_hz   = 1'b0;
		fmt_err = 1'b0;
		rng_err = 1'b0;
		raw     = 40'h0;
		full    = `PRD_BIN_FULL8;
		neg     = pins_s.sign; // [RL19]
		if (display_unit_select >= `PRD_UNIT_RPM_LO &&
			display_unit_select <= `PRD_UNIT_RPM_HI) begin
			lim = use_d3 ? `PRD_LIM_RPM16 : `PRD_LIM_RPM12; // [RL15]
		end else if (display_unit_select >= `PRD_UNIT_USER_LO) begin
			lim = `PRD_LIM_USER; // [RL16]
		end else begin
			unique case (input_format_select)
				PRD_FMT_PCT1: begin
					val    = mag * 40'd100; // [RL7] [RL10]
					is_pct = 1'b1;
				end
				PRD_FMT_PCT01: begin
					val    = mag * 40'd10; // [RL8]
					is_pct = 1'b1;
				end
				PRD_FMT_PCT001: begin
					is_pct = 1'b1; // [RL8]
				end
				PRD_FMT_HZ1: begin
					val   = mag * 40'd100; // [RL9] [RL11]
					is_hz = 1'b1;
					lim   = `PRD_LIM_HZ;
				end
				PRD_FMT_HZ01: begin
					val   = mag * 40'd10; // [RL9]
					is_hz = 1'b1;
					lim   = `PRD_LIM_HZ;
				end
				PRD_FMT_HZ001: begin
					is_hz = 1'b1; // [RL9]
					lim   = use_d3 ? `PRD_LIM_HZ_FINE : `PRD_LIM_HZ; // [RL12]
				end
				PRD_FMT_BCD5: begin
					is_hz   = 1'b1;
					neg     = 1'b0; // [RL3]
					lim     = `PRD_LIM_BCD5; // [RL2] [RL13]
					fmt_err = !use_d3; // [RL5]
				end
				PRD_FMT_BIN: begin
					is_pct = 1'b1;
					if (!card16) begin
						raw  = 40'(pins_s.data[7:0]); // [RL6]
						full = `PRD_BIN_FULL8;
					end else if (!word_width_switch) begin
						raw  = 40'(pins_s.data[11:0]);
						full = `PRD_BIN_FULL12;
					end else begin
						raw  = 40'(pins_s.data);
						full = `PRD_BIN_FULL16; // [RL14]
					end
					if ((!card16 && &pins_s.data[7:0]) ||
						(card16 && !word_width_switch && &pins_s.data[11:0]) ||
						(card16 && word_width_switch && &pins_s.data)) begin
						val = `PRD_FULL_PCT; // [RL1]
					end else begin
						val = raw * `PRD_FULL_PCT / full;
						rng_err = card16 && word_width_switch &&
							(raw > `PRD_LIM_BIN16); // [RL14]
					end
					lim = 40'hff_ffff_ffff;
				end
			endcase
		end
		if (val > lim) begin
			rng_err = 1'b1;
		end
		// percent and hertz meet at the top frequency
		conv = val;
		if (is_pct && display_unit_select == 16'h0000) begin
			conv = val * `PRD_MAX_FREQ_CHZ / `PRD_FULL_PCT; // [RL17]
		end else if (is_hz && display_unit_select == 16'h0001) begin
			conv = val * `PRD_FULL_PCT / `PRD_MAX_FREQ_CHZ; // [RL17]
		end
	end

	// capture: only while strobe high, bad words leave the monitor untouched
	always_comb begin
		next_mon    = reference_monitor;
		next_status = status;
		if (pins_s.strobe) begin // [RL19]
			next_status.bcd_err = bcd_err && !(input_format_select == PRD_FMT_BIN &&
				display_unit_select < `PRD_UNIT_RPM_LO);
			next_status.rng_err = rng_err;
			next_status.fmt_err = fmt_err;
			if (!(next_status.bcd_err || rng_err || fmt_err)) begin // [RL20] [RL5]
				next_mon            = neg ? 32'(40'h0 - conv) : conv[31:0];
				next_status.valid   = 1'b1;
				next_status.reverse = neg;
			end
		end
	end

	// register port
	always_comb begin
		next_ctrl  = ctrl;
		next_unit  = display_unit_select;
		next_rdata = 32'h0;
		if (bus_wr && bus_addr == `PRD_OFS_CTRL) begin
			next_ctrl = bus_wdata[4:0];
		end
		if (bus_wr && bus_addr == `PRD_OFS_UNIT) begin
			next_unit = bus_wdata[15:0];
		end
		if (bus_rd) begin
			unique case (bus_addr)
				`PRD_OFS_CTRL: next_rdata = {27'h0, ctrl};
				`PRD_OFS_UNIT: next_rdata = {16'h0, display_unit_select};
				`PRD_OFS_MON:  next_rdata = reference_monitor;
				`PRD_OFS_STAT: next_rdata = {27'h0, status};
				default:       next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl                <= `PRD_CTRL_RST;
			display_unit_select <= `PRD_UNIT_RST;
			bus_rdata           <= 32'h0;
			reference_monitor   <= 32'h0;
			status              <= '0;
		end else begin
			ctrl                <= next_ctrl;
			display_unit_select <= next_unit;
			bus_rdata           <= next_rdata;
			reference_monitor   <= next_mon;
			status              <= next_status;
		end
	end

	// checks
	logic cfg8_bcd5;
	logic cfg_unit1;
	assign cfg8_bcd5 = !card16 && input_format_select == PRD_FMT_BCD5 &&
		display_unit_select < `PRD_UNIT_RPM_LO;
	assign cfg_unit1 = display_unit_select == 16'h0001;

	all_ones_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL1]
		pins_s.strobe && cfg_unit1 && input_format_select == PRD_FMT_BIN && card16 &&
		word_width_switch && &pins_s.data && !pins_s.sign && !bus_wr
		|=> reference_monitor == 32'h2710)
		else $error("all ones binary word did not give full scale");

	narrow_bcd5_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL5]
		pins_s.strobe && cfg8_bcd5 && !bus_wr |=> status.fmt_err && $stable(reference_monitor))
		else $error("narrow card accepted the five digit format");

	bcd5_pos_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL3]
		pins_s.strobe && input_format_select == PRD_FMT_BCD5 && !bus_wr &&
		display_unit_select == 16'h0000 |=> !status.fmt_err && !status.bcd_err |->
		!reference_monitor[31])
		else $error("unsigned format produced a negative value");

	bcd5_even_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL4]
		pins_s.strobe && input_format_select == PRD_FMT_BCD5 && !bus_wr &&
		display_unit_select == 16'h0000 |=> !status.fmt_err && !status.bcd_err |->
		status.valid && !reference_monitor[0] && reference_monitor <= 32'h9c3e)
		else $error("unsigned format step or limit wrong");

	bad_digit_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL20]
		pins_s.strobe && !bus_wr && display_unit_select < `PRD_UNIT_RPM_LO &&
		input_format_select != PRD_FMT_BIN && (input_format_select == PRD_FMT_BCD5 ?
		pins_s.data[2:0] > 3'h4 : pins_s.data[3:0] > 4'h9)
		|=> status.bcd_err && $stable(reference_monitor))
		else $error("illegal digit not rejected");

	no_strobe_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL19]
		!pins_s.strobe |=> $stable(reference_monitor) && $stable(status))
		else $error("reference changed without strobe");

	pct1_step_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL7]
		pins_s.strobe && cfg_unit1 && !bus_wr && input_format_select == PRD_FMT_PCT1
		&& !pins_s.sign && pins_s.data[7:0] == 8'h42 && !card16
		|=> reference_monitor == 32'h1068)
		else $error("one percent BCD decode wrong");

	bin8_range_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL6]
		pins_s.strobe && cfg_unit1 && !bus_wr && input_format_select == PRD_FMT_BIN
		&& !card16 && pins_s.sign && pins_s.data[7:0] == 8'hff
		|=> reference_monitor == 32'hffff_d8f0 && status.reverse)
		else $error("narrow binary reverse full scale wrong");

	hz1_unit0_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL17]
		pins_s.strobe && !bus_wr && display_unit_select == 16'h0000 && card16 &&
		word_width_switch && input_format_select == PRD_FMT_HZ1 &&
		!pins_s.sign && pins_s.data == 16'h0399
		|=> reference_monitor == 32'h9bdc)
		else $error("hertz monitor scaling wrong");

endmodule : prd_decoder

`default_nettype wire

// ===== testbench/prd_ref_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module prd_ref_ctrl (
	// clock
	input  wire logic              sys_clk,
	// reference lines towards the decoder
	output var prd_pkg::prd_pins_t pins
);
	import prd_pkg::*;

	initial begin
		pins = '0;
	end

	// word and sign are set a cycle ahead and held past the strobe,
	// so every sampled strobe cycle sees one stable word
	task automatic send(input logic [15:0] d, input logic s, input logic strobe_on);
		@(posedge sys_clk);
		pins.data <= d;
		pins.sign <= s;
		@(posedge sys_clk);
		pins.strobe <= strobe_on;
		repeat (4) @(posedge sys_clk);
		pins.strobe <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask : send
endmodule : prd_ref_ctrl

`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "prd_map.svh"

module testbench;
	import prd_pkg::*;

	logic        sys_clk;
	logic        rst;
	prd_pins_t   pins;
	logic [7:0]  bus_addr;
	logic [31:0] bus_wdata;
	logic        bus_wr;
	logic        bus_rd;
	logic [31:0] bus_rdata;
	logic [31:0] reference_monitor;
	prd_status_t status;
	int          n_fail;
	int          cmp_count;
	int          n_test;
	int          cycles;
	logic [31:0] v;

	prd_decoder prd_decoder_inst (
		.sys_clk           (sys_clk),
		.rst               (rst),
		.pins              (pins),
		.bus_addr          (bus_addr),
		.bus_wdata         (bus_wdata),
		.bus_wr            (bus_wr),
		.bus_rd            (bus_rd),
		.bus_rdata         (bus_rdata),
		.reference_monitor (reference_monitor),
		.status            (status)
	);

	prd_ref_ctrl prd_ref_ctrl_inst (
		.sys_clk (sys_clk),
		.pins    (pins)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop

	// hang guard, well above the roughly 480 cycles the tests need
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus_wr    <= 1'b1;
		bus_addr  <= a;
		bus_wdata <= d;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		bus_rd   <= 1'b1;
		bus_addr <= a;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask : rd

	task automatic t(input logic [4:0] c, input logic [15:0] u, input logic [15:0] d,
		input logic s, input logic on, input logic [31:0] m, input logic [4:0] st);
		wr(`PRD_OFS_CTRL, {27'h0, c});
		wr(`PRD_OFS_UNIT, {16'h0, u});
		prd_ref_ctrl_inst.send(d, s, on);
		chk("monitor port", m, reference_monitor);
		chk("status port", {27'h0, st}, {27'h0, status});
		rd(`PRD_OFS_MON, v);
		chk("mon reg", m, v);
		rd(`PRD_OFS_STAT, v);
		chk("stat reg", {27'h0, st}, v);
		n_test++;
		$display("test %0d done", n_test);
	endtask : t

	initial begin
		rst       = 1'b1;
		bus_addr  = 8'h00;
		bus_wdata = 32'h0;
		bus_wr    = 1'b0;
		bus_rd    = 1'b0;
		n_fail    = 0;
		cmp_count = 0;
		n_test    = 0;
		cycles    = 0;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rd(`PRD_OFS_CTRL, v);
		chk("ctrl reset", {27'h0, `PRD_CTRL_RST}, v);
		rd(`PRD_OFS_UNIT, v);
		chk("unit reset", {16'h0, `PRD_UNIT_RST}, v);
		rd(8'h10, v);
		chk("unmapped", 32'h0, v);
		rd(`PRD_OFS_MON, v);
		chk("mon reset", 32'h0, v);
		// narrow card
		t(5'h00, 16'h1, 16'h0045, 1'b1, 1'b1, 32'hffffee6c, 5'h11);
		t(5'h00, 16'h1, 16'h0099, 1'b0, 1'b0, 32'hffffee6c, 5'h11);
		t(5'h00, 16'h1, 16'h000a, 1'b0, 1'b1, 32'hffffee6c, 5'h13);
		t(5'h07, 16'h1, 16'h00ff, 1'b0, 1'b1, 32'h00002710, 5'h01);
		t(5'h07, 16'h1, 16'h00ff, 1'b1, 1'b1, 32'hffffd8f0, 5'h11);
		t(5'h06, 16'h1, 16'h0012, 1'b0, 1'b1, 32'hffffd8f0, 5'h19);
		t(5'h01, 16'h1, 16'h0012, 1'b0, 1'b1, 32'h00000078, 5'h01);
		t(5'h02, 16'h1, 16'h0012, 1'b0, 1'b1, 32'h0000000c, 5'h01);
		t(5'h03, 16'h0, 16'h0012, 1'b0, 1'b1, 32'h000004b0, 5'h01);
		t(5'h04, 16'h0, 16'h0012, 1'b0, 1'b1, 32'h00000078, 5'h01);
		t(5'h05, 16'h0, 16'h0012, 1'b0, 1'b1, 32'h0000000c, 5'h01);
		t(5'h00, 16'h1, 16'h0042, 1'b0, 1'b1, 32'h00001068, 5'h01);
		t(5'h00, 16'h0, 16'h0050, 1'b0, 1'b1, 32'h00000bb8, 5'h01);
		t(5'h03, 16'h1, 16'h0030, 1'b0, 1'b1, 32'h00001388, 5'h01);
		// wide card, 16-bit width, plus format 6 at 12-bit width
		t(5'h18, 16'h1, 16'h0110, 1'b0, 1'b1, 32'h00002af8, 5'h01);
		t(5'h18, 16'h1, 16'h0111, 1'b0, 1'b1, 32'h00002af8, 5'h05);
		t(5'h1b, 16'h0, 16'h0400, 1'b1, 1'b1, 32'hffff63c0, 5'h11);
		t(5'h1b, 16'h0, 16'h0399, 1'b0, 1'b1, 32'h00009bdc, 5'h01);
		t(5'h1d, 16'h0, 16'h1599, 1'b0, 1'b1, 32'h0000063f, 5'h01);
		t(5'h1e, 16'h0, 16'hcccc, 1'b1, 1'b1, 32'h00009c3e, 5'h01);
		t(5'h16, 16'h0, 16'h0012, 1'b0, 1'b1, 32'h00009c3e, 5'h09);
		t(5'h1f, 16'h1, 16'h7530, 1'b0, 1'b1, 32'h00002710, 5'h01);
		t(5'h1f, 16'h1, 16'h80e9, 1'b0, 1'b1, 32'h00002710, 5'h05);
		t(5'h18, 16'h5, 16'h1234, 1'b0, 1'b1, 32'h000004d2, 5'h01);
		t(5'h18, 16'h28, 16'h9999, 1'b1, 1'b1, 32'hffffd8f1, 5'h11);
		t(5'h1f, 16'h1, 16'hffff, 1'b0, 1'b1, 32'h00002710, 5'h01);
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire
